// [cptr_consts.svh]
// offsets, field positions, reset values and timing counts of the bank
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef CPTR_CONSTS_SVH
`define CPTR_CONSTS_SVH

// register indices as printed; byte address is four times the index
`define CPTR_IDX_CLK_PREP 8'h40
`define CPTR_IDX_CLK_ZERO 8'h41
`define CPTR_IDX_CLK_TRAIL 8'h42
`define CPTR_IDX_CLK_POST 8'h43
`define CPTR_IDX_DATA_PREP 8'h44
`define CPTR_IDX_RATE_CTRL 8'h48
`define CPTR_IDX_LINK_STAT 8'h49

// field positions inside a timing register
`define CPTR_OV_BIT 7
`define CPTR_VAL_MSB 6

// value-field reset values, taken at the 800 Mbps lane rate
`define CPTR_RST_CLK_PREP 7'h05
`define CPTR_RST_CLK_ZERO 7'h1B
`define CPTR_RST_CLK_TRAIL 7'h0B
`define CPTR_RST_CLK_POST 7'h0A
`define CPTR_RST_DATA_PREP 7'h06

// rate scale in quarters of the 800 Mbps figure
`define CPTR_SCALE_400 4'h2
`define CPTR_SCALE_800 4'h4
`define CPTR_SCALE_1200 4'h6
`define CPTR_SCALE_1500 4'h8
`define CPTR_SCALE_1600 4'h8

// answer codes of the register bus
`define CPTR_RESP_OKAY 2'h0
`define CPTR_RESP_DECERR 2'h3

`endif

// [cptr_pkg.sv]
// types shared by the timing-override register bank
package cptr_pkg;

   // selectable lane rates
   typedef enum logic [2:0] {
      CPTR_RATE_400 = 3'b000,
      CPTR_RATE_800 = 3'b001,
      CPTR_RATE_1200 = 3'b010,
      CPTR_RATE_1500 = 3'b011,
      CPTR_RATE_1600 = 3'b100
   } cptr_rate_e;

   // transmitter lane states of one low-power to high-speed cycle
   typedef enum logic [2:0] {
      CPTR_LANE_LP = 3'b000,
      CPTR_LANE_CLK_PREP = 3'b001,
      CPTR_LANE_CLK_ZERO = 3'b010,
      CPTR_LANE_DATA_PREP = 3'b011,
      CPTR_LANE_HS = 3'b100,
      CPTR_LANE_CLK_POST = 3'b101,
      CPTR_LANE_CLK_TRAIL = 3'b110
   } cptr_lane_e;

   // one 7-bit timing value
   typedef logic [6:0] cptr_val_t;

endpackage

// [cptr_auto_table.sv]
// automatic timing values derived from the selected lane rate
`timescale 1ns/1ps
`include "cptr_consts.svh"

module cptr_auto_table (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // rate selection
   input wire cptr_pkg::cptr_rate_e rateSel,
   // automatic values, registered
   output cptr_pkg::cptr_val_t autoClkPrep,
   output cptr_pkg::cptr_val_t autoClkZero,
   output cptr_pkg::cptr_val_t autoClkTrail,
   output cptr_pkg::cptr_val_t autoClkPost,
   output cptr_pkg::cptr_val_t autoDataPrep
);

   // scale an 800 Mbps figure by quarters, rounding up, saturating
   function automatic cptr_pkg::cptr_val_t scaleVal(
      input logic [6:0] base,
      input logic [3:0] quarters
   );
      logic [11:0] prod;
      prod = 12'({5'h00, base} * {8'h00, quarters}) + 12'h003;
      if (prod[11:2] > 10'h07F) begin
         scaleVal = 7'h7F;
      end else begin
         scaleVal = prod[8:2];
      end
   endfunction

   // scale factor of the selected rate
   logic [3:0] scale;
   always_comb begin
      case (rateSel)
         cptr_pkg::CPTR_RATE_400: scale = `CPTR_SCALE_400;
         cptr_pkg::CPTR_RATE_800: scale = `CPTR_SCALE_800;
         cptr_pkg::CPTR_RATE_1200: scale = `CPTR_SCALE_1200;
         cptr_pkg::CPTR_RATE_1500: scale = `CPTR_SCALE_1500;
         cptr_pkg::CPTR_RATE_1600: scale = `CPTR_SCALE_1600;
         default: scale = `CPTR_SCALE_800;
      endcase
   end

   // values follow the rate; reset values are the 800 Mbps ones
   always_ff @(posedge core_clk) begin
      if (srst) begin
         autoClkPrep <= `CPTR_RST_CLK_PREP;
         autoClkZero <= `CPTR_RST_CLK_ZERO;
         autoClkTrail <= `CPTR_RST_CLK_TRAIL;
         autoClkPost <= `CPTR_RST_CLK_POST;
         autoDataPrep <= `CPTR_RST_DATA_PREP;
      end else begin
         autoClkPrep <= scaleVal(`CPTR_RST_CLK_PREP, scale);
         autoClkZero <= scaleVal(`CPTR_RST_CLK_ZERO, scale);
         autoClkTrail <= scaleVal(`CPTR_RST_CLK_TRAIL, scale);
         autoClkPost <= scaleVal(`CPTR_RST_CLK_POST, scale);
         autoDataPrep <= scaleVal(`CPTR_RST_DATA_PREP, scale);
      end
   end

endmodule

// [cptr_lane_seq.sv]
// lane sequencer timing the prepare, zero, post and trail states by the effective values; LP and HS follow hsReq
`timescale 1ns/1ps
`include "cptr_consts.svh"

module cptr_lane_seq (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // high-speed burst request, level
   input wire logic hsReq,
   // effective durations in byte-clock cycles
   input wire cptr_pkg::cptr_val_t durClkPrep,
   input wire cptr_pkg::cptr_val_t durClkZero,
   input wire cptr_pkg::cptr_val_t durClkTrail,
   input wire cptr_pkg::cptr_val_t durClkPost,
   input wire cptr_pkg::cptr_val_t durDataPrep,
   // lane state, registered
   output cptr_pkg::cptr_lane_e laneState,
   output logic hsActive
);

   // cycles left in the current state
   logic [6:0] cnt_r;
   cptr_pkg::cptr_lane_e stateNxt;
   logic [6:0] durNxt;
   wire logic done = (cnt_r <= 7'h01);

   // a zero duration still lasts one cycle
   function automatic logic [6:0] atLeastOne(input logic [6:0] v);
      atLeastOne = (v == 7'h00) ? 7'h01 : v;
   endfunction

   // next state and its duration
   always_comb begin
      stateNxt = laneState;
      durNxt = cnt_r - 7'h01;
      case (laneState)
         cptr_pkg::CPTR_LANE_LP: begin
            durNxt = 7'h00;
            if (hsReq) begin
               stateNxt = cptr_pkg::CPTR_LANE_CLK_PREP;
               durNxt = atLeastOne(durClkPrep);
            end
         end
         cptr_pkg::CPTR_LANE_CLK_PREP: if (done) begin
            stateNxt = cptr_pkg::CPTR_LANE_CLK_ZERO;
            durNxt = atLeastOne(durClkZero);
         end
         cptr_pkg::CPTR_LANE_CLK_ZERO: if (done) begin
            stateNxt = cptr_pkg::CPTR_LANE_DATA_PREP;
            durNxt = atLeastOne(durDataPrep);
         end
         cptr_pkg::CPTR_LANE_DATA_PREP: if (done) begin
            stateNxt = cptr_pkg::CPTR_LANE_HS;
            durNxt = 7'h00;
         end
         cptr_pkg::CPTR_LANE_HS: begin
            durNxt = 7'h00;
            if (!hsReq) begin
               stateNxt = cptr_pkg::CPTR_LANE_CLK_POST;
               durNxt = atLeastOne(durClkPost);
            end
         end
         cptr_pkg::CPTR_LANE_CLK_POST: if (done) begin
            stateNxt = cptr_pkg::CPTR_LANE_CLK_TRAIL;
            durNxt = atLeastOne(durClkTrail);
         end
         cptr_pkg::CPTR_LANE_CLK_TRAIL: if (done) begin
            stateNxt = cptr_pkg::CPTR_LANE_LP;
            durNxt = 7'h00;
         end
         default: begin
            stateNxt = cptr_pkg::CPTR_LANE_LP;
            durNxt = 7'h00;
         end
      endcase
   end

   // state, counter and burst flag
   always_ff @(posedge core_clk) begin
      if (srst) begin
         laneState <= cptr_pkg::CPTR_LANE_LP;
         cnt_r <= 7'h00;
         hsActive <= 1'b0;
      end else begin
         laneState <= stateNxt;
         cnt_r <= durNxt;
         hsActive <= (stateNxt == cptr_pkg::CPTR_LANE_HS);
      end
   end

endmodule

// [cptr_timing_regs.sv]
// timing-override register bank with its AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cptr_consts.svh"

module cptr_timing_regs #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // write address channel
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // burst request from the packet path
   input wire logic hsReq,
   // effective timing values, registered
   output cptr_pkg::cptr_val_t effClkPrep,
   output cptr_pkg::cptr_val_t effClkZero,
   output cptr_pkg::cptr_val_t effClkTrail,
   output cptr_pkg::cptr_val_t effClkPost,
   output cptr_pkg::cptr_val_t effDataPrep,
   // transmitter lane state
   output cptr_pkg::cptr_lane_e laneState,
   output logic hsActive
);

   //-------------------------------------------------------------------
   // decode helpers
   //-------------------------------------------------------------------

   // index of a word address; upper bits must be zero to hit
   function automatic logic [8:0] wordIdx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = a >> 2;
      wordIdx = {(w > ADDR_W'(8'hFF)), w[7:0]};
   endfunction

   // one-hot hit vector: 0..4 timing, 5 rate control, 6 status
   function automatic logic [6:0] hitVec(input logic [8:0] idx);
      hitVec = 7'h00;
      if (!idx[8]) begin
         hitVec[0] = (idx[7:0] == `CPTR_IDX_CLK_PREP);
         hitVec[1] = (idx[7:0] == `CPTR_IDX_CLK_ZERO);
         hitVec[2] = (idx[7:0] == `CPTR_IDX_CLK_TRAIL);
         hitVec[3] = (idx[7:0] == `CPTR_IDX_CLK_POST);
         hitVec[4] = (idx[7:0] == `CPTR_IDX_DATA_PREP);
         hitVec[5] = (idx[7:0] == `CPTR_IDX_RATE_CTRL);
         hitVec[6] = (idx[7:0] == `CPTR_IDX_LINK_STAT);
      end
   endfunction

   // a rate code is valid only for the five listed rates
   function automatic logic rateOk(input logic [2:0] code);
      rateOk = (code <= 3'h4);
   endfunction

   // value in force: written value under override, else automatic
   function automatic cptr_pkg::cptr_val_t pickVal(
      input logic ov,
      input cptr_pkg::cptr_val_t sw,
      input cptr_pkg::cptr_val_t au
   );
      pickVal = ov ? sw : au;
   endfunction

   //-------------------------------------------------------------------
   // register state
   //-------------------------------------------------------------------

   // override bits, one per timing register
   logic [4:0] ov_r;
   // software values, used while the override bit is set
   cptr_pkg::cptr_val_t swVal_r [5];
   // selected lane rate
   cptr_pkg::cptr_rate_e rate_r;
   // automatic values from the rate table
   cptr_pkg::cptr_val_t autoVal [5];
   // effective values, one per timing register
   cptr_pkg::cptr_val_t effVal [5];

   // write-side holding registers
   logic awHeld_r;
   logic wHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [7:0] wByte_r;
   logic wLane0_r;

   //-------------------------------------------------------------------
   // write channel
   //-------------------------------------------------------------------

   // handshakes on each channel
   wire logic awFire = s_axi_awvalid & s_axi_awready;
   wire logic wFire = s_axi_wvalid & s_axi_wready;
   wire logic bFire = s_axi_bvalid & s_axi_bready;
   // address and data both present, no answer pending
   wire logic wrGo = awHeld_r & wHeld_r & ~s_axi_bvalid;
   // decoded write target
   wire logic [6:0] wrHit = hitVec(wordIdx(awAddr_r));
   // writable targets; status is read-only but still answers OKAY
   wire logic wrMapped = |wrHit;
   // a write that really changes state
   wire logic wrDo = wrGo & wLane0_r;
   // override bit carried by the written byte
   wire logic wrOv = wByte_r[`CPTR_OV_BIT];
   // value field carried by the written byte
   wire cptr_pkg::cptr_val_t wrVal = wByte_r[`CPTR_VAL_MSB:0];

   // accept address and data in either order, one write at a time
   always_ff @(posedge core_clk) begin
      if (srst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wByte_r <= 8'h00;
         wLane0_r <= 1'b0;
      end else begin
         if (awFire) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end else if (wrGo) begin
            awHeld_r <= 1'b0;
         end
         if (wFire) begin
            wHeld_r <= 1'b1;
            wByte_r <= s_axi_wdata[7:0];
            wLane0_r <= s_axi_wstrb[0];
         end else if (wrGo) begin
            wHeld_r <= 1'b0;
         end
      end
   end

   // ready flags re-open once the answer has been taken
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         if (awFire) begin
            s_axi_awready <= 1'b0;
         end else if (!awHeld_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (wFire) begin
            s_axi_wready <= 1'b0;
         end else if (!wHeld_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write answer, unmapped addresses get a decode error
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CPTR_RESP_OKAY;
      end else if (wrGo) begin
         // both halves held: answer now
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? `CPTR_RESP_OKAY : `CPTR_RESP_DECERR;
      end else if (bFire) begin
         // answer taken by the master
         s_axi_bvalid <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // timing registers
   //-------------------------------------------------------------------

   // override bits are always writable; the value field is taken only
   // when the byte written leaves the override bit set
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_tim
         always_ff @(posedge core_clk) begin
            if (srst) begin
               ov_r[gi] <= 1'b0;
               swVal_r[gi] <= 7'h00;
            end else if (wrDo && wrHit[gi]) begin
               ov_r[gi] <= wrOv;
               if (wrOv) begin
                  swVal_r[gi] <= wrVal;
               end
            end
         end
      end
   endgenerate

   // rate control; codes outside the table are ignored
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rate_r <= cptr_pkg::CPTR_RATE_800;
      end else if (wrDo && wrHit[5] && rateOk(wByte_r[2:0])) begin
         rate_r <= cptr_pkg::cptr_rate_e'(wByte_r[2:0]);
      end
   end

   //-------------------------------------------------------------------
   // automatic values and selection
   //-------------------------------------------------------------------

   // rate table
   cptr_auto_table u_auto (
      .core_clk (core_clk),
      .srst (srst),
      .rateSel (rate_r),
      .autoClkPrep (autoVal[0]),
      .autoClkZero (autoVal[1]),
      .autoClkTrail (autoVal[2]),
      .autoClkPost (autoVal[3]),
      .autoDataPrep (autoVal[4])
   );

   // pick software value or automatic value per register
   assign effVal[0] = pickVal(ov_r[0], swVal_r[0], autoVal[0]);
   assign effVal[1] = pickVal(ov_r[1], swVal_r[1], autoVal[1]);
   assign effVal[2] = pickVal(ov_r[2], swVal_r[2], autoVal[2]);
   assign effVal[3] = pickVal(ov_r[3], swVal_r[3], autoVal[3]);
   assign effVal[4] = pickVal(ov_r[4], swVal_r[4], autoVal[4]);

   // effective values to the transmitter, registered
   always_ff @(posedge core_clk) begin
      if (srst) begin
         effClkPrep <= `CPTR_RST_CLK_PREP;
         effClkZero <= `CPTR_RST_CLK_ZERO;
         effClkTrail <= `CPTR_RST_CLK_TRAIL;
         effClkPost <= `CPTR_RST_CLK_POST;
         effDataPrep <= `CPTR_RST_DATA_PREP;
      end else begin
         effClkPrep <= effVal[0];
         effClkZero <= effVal[1];
         effClkTrail <= effVal[2];
         effClkPost <= effVal[3];
         effDataPrep <= effVal[4];
      end
   end

   //-------------------------------------------------------------------
   // lane sequencer
   //-------------------------------------------------------------------

   // runs the low-power to high-speed states on the effective values
   cptr_lane_seq u_seq (
      .core_clk (core_clk),
      .srst (srst),
      .hsReq (hsReq),
      .durClkPrep (effClkPrep),
      .durClkZero (effClkZero),
      .durClkTrail (effClkTrail),
      .durClkPost (effClkPost),
      .durDataPrep (effDataPrep),
      .laneState (laneState),
      .hsActive (hsActive)
   );

   //-------------------------------------------------------------------
   // read channel
   //-------------------------------------------------------------------

   // read handshakes
   wire logic arFire = s_axi_arvalid & s_axi_arready;
   wire logic rFire = s_axi_rvalid & s_axi_rready;
   // decoded read target
   wire logic [6:0] rdHit = hitVec(wordIdx(s_axi_araddr));
   // read word of a timing register: override bit over chosen value
   logic [7:0] rdTim;
   // whole read word
   logic [31:0] rdWord;

   // timing registers read back the value in force
   always_comb begin
      rdTim = 8'h00;
      for (int i = 0; i < 5; i++) begin
         if (rdHit[i]) begin
            rdTim = {ov_r[i], effVal[i]};
         end
      end
   end

   // select among timing, control and status words
   always_comb begin
      rdWord = 32'h0000_0000;
      if (|rdHit[4:0]) begin
         rdWord = {24'h00_0000, rdTim};
      end else if (rdHit[5]) begin
         rdWord = {29'h0000_0000, rate_r};
      end else if (rdHit[6]) begin
         rdWord = {28'h000_0000, hsActive, laneState};
      end
   end

   // one read at a time; address ready reopens after data taken
   always_ff @(posedge core_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CPTR_RESP_OKAY;
      end else begin
         if (arFire) begin
            // address taken: answer stands until taken
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= (|rdHit) ? `CPTR_RESP_OKAY : `CPTR_RESP_DECERR;
         end else begin
            if (rFire) begin
               // data taken by the master
               s_axi_rvalid <= 1'b0;
            end
            if (!s_axi_rvalid || rFire) begin
               s_axi_arready <= 1'b1;
            end
         end
      end
   end

endmodule

// [cptr_timing_regs_asserts.sv]
// port checker for the timing-override register bank
`timescale 1ns/1ps
`include "cptr_consts.svh"

module cptr_timing_regs_asserts (
   // clock and reset
   input logic core_clk,
   input logic srst,
   // bus handshakes
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // lane side
   input cptr_pkg::cptr_val_t effClkPrep,
   input cptr_pkg::cptr_val_t effClkZero,
   input cptr_pkg::cptr_val_t effClkTrail,
   input cptr_pkg::cptr_val_t effClkPost,
   input cptr_pkg::cptr_val_t effDataPrep,
   input cptr_pkg::cptr_lane_e laneState,
   input logic hsActive
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   cptr_pkg::cptr_lane_e prevSt_r; // lane state one edge earlier
   logic [6:0] stCnt_r; // cycles spent in the current state
   // count cycles of each lane state visit
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prevSt_r <= cptr_pkg::CPTR_LANE_LP;
         stCnt_r <= 7'h00;
      end else begin
         prevSt_r <= laneState;
         stCnt_r <= (laneState != prevSt_r) ? 7'h01 : stCnt_r + 7'h01;
      end
   end
   property p_rst_vals;
      $fell(srst) |-> effClkPrep == `CPTR_RST_CLK_PREP
         && effClkZero == `CPTR_RST_CLK_ZERO
         && effClkTrail == `CPTR_RST_CLK_TRAIL
         && effClkPost == `CPTR_RST_CLK_POST
         && effDataPrep == `CPTR_RST_DATA_PREP;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("bad reset values");
   property p_prep_len;
      (prevSt_r == cptr_pkg::CPTR_LANE_CLK_PREP && laneState != prevSt_r)
         |-> stCnt_r == ((effClkPrep == 7'h00) ? 7'h01 : effClkPrep);
   endproperty
   a_prep_len: assert property (p_prep_len)
      else $error("clock prepare length wrong");
   property p_dprep_len;
      (prevSt_r == cptr_pkg::CPTR_LANE_DATA_PREP && laneState != prevSt_r)
         |-> stCnt_r == ((effDataPrep == 7'h00) ? 7'h01 : effDataPrep);
   endproperty
   a_dprep_len: assert property (p_dprep_len)
      else $error("data prepare length wrong");
   property p_hs_level;
      hsActive == (laneState == cptr_pkg::CPTR_LANE_HS);
   endproperty
   a_hs_level: assert property (p_hs_level)
      else $error("burst flag wrong");
   property p_wr_lat;
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
         |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_burst: cover property ($rose(hsActive));
endmodule

bind cptr_timing_regs cptr_timing_regs_asserts chk_u (.*);

// [cptr_rx_model.sv]
// receiver model that times each lane state it sees
`timescale 1ns/1ps

module cptr_rx_model (
   // clock and reset
   input logic core_clk,
   input logic srst,
   // lane as the receiver sees it
   input cptr_pkg::cptr_lane_e laneState,
   // cycles of each state on its last visit
   output logic [7:0] seenLen [8],
   // pulse when the lane is back in low power
   output logic burstDone
);
   cptr_pkg::cptr_lane_e prev_r; // state one edge earlier
   logic [7:0] cnt_r; // cycles in the current state
   // measure every state visit
   always_ff @(posedge core_clk) begin
      burstDone <= 1'b0;
      if (srst) begin
         prev_r <= cptr_pkg::CPTR_LANE_LP;
         cnt_r <= 8'h00;
      end else begin
         prev_r <= laneState;
         if (laneState != prev_r) begin
            seenLen[prev_r] <= cnt_r;
            cnt_r <= 8'h01;
            burstDone <= (laneState == cptr_pkg::CPTR_LANE_LP);
         end else begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule

// [tb.sv]
// self-checking bench for the timing-override register bank
`timescale 1ns/1ps
`include "cptr_consts.svh"

module tb;
   //--------
   // signals
   //--------
   logic core_clk = 1'b0, srst = 1'b1, hsReq = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, hsActive, burstDone;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   cptr_pkg::cptr_val_t effClkPrep, effClkZero, effClkTrail;
   cptr_pkg::cptr_val_t effClkPost, effDataPrep;
   cptr_pkg::cptr_lane_e laneState;
   logic [7:0] seenLen [8];
   logic [33:0] rdQ[$]; // expected {rresp, rdata}
   logic [1:0] bQ[$]; // expected bresp
   logic [7:0] lenQ[$]; // expected state lengths
   int stL[5] = '{1, 2, 6, 5, 3}; // lane state of each register
   int bad_count = 0, n_checks = 0;
   cptr_timing_regs #(.ADDR_W(12)) dut_u (
      .core_clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hsReq,
      .effClkPrep, .effClkZero, .effClkTrail, .effClkPost, .effDataPrep,
      .laneState, .hsActive
   );
   cptr_rx_model rx_u (.core_clk, .srst, .laneState, .seenLen, .burstDone);
   initial forever #20 core_clk = ~core_clk;
   //--------
   // helpers
   //--------
   // compare and count
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // byte address of timing register i
   function automatic logic [11:0] ad(input int i);
      return 12'h100 + 12'(i * 4);
   endfunction
   // expected automatic value
   function automatic logic [6:0] av(input logic [6:0] b, input int q);
      int t;
      t = (b * q + 3) / 4;
      return (t > 127) ? 7'h7F : 7'(t);
   endfunction
   // one bus write
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      bQ.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'(d);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         s_axi_bready <= s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
   endtask
   // one bus read
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      rdQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         s_axi_rready <= s_axi_rvalid;
      end
      s_axi_rready <= 1'b0;
   endtask
   // report and end the run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // monitor: oldest note against each result
   always @(posedge core_clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready) begin
         chk(34'(s_axi_bresp), 34'(bQ.pop_front()));
      end
      if (burstDone) begin
         for (int i = 0; i < 5; i++) begin
            chk(34'(seenLen[stL[i]]), 34'(lenQ.pop_front()));
         end
      end
   end
   // watchdog
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      stop_test();
   end
   //--------
   // tests
   //--------
   initial begin
      int q[5] = '{2, 4, 6, 8, 8}; // quarters per rate code
      logic [6:0] rv[5];
      logic [6:0] v[5];
      rv = '{`CPTR_RST_CLK_PREP, `CPTR_RST_CLK_ZERO, `CPTR_RST_CLK_TRAIL,
             `CPTR_RST_CLK_POST, `CPTR_RST_DATA_PREP};
      void'($urandom(32'hE0F961DA));
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 5; i++) rd(ad(i), 34'(rv[i]));
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         wr(ad(i), {1'b0, 7'($urandom)}, 2'b00);
         rd(ad(i), 34'(rv[i]));
      end
      $display("test read-only field done");
      for (int r = 0; r < 5; r++) begin
         wr(12'h120, 8'(r), 2'b00);
         rd(12'h120, 34'(r));
         for (int i = 0; i < 5; i++) rd(ad(i), 34'(av(rv[i], q[r])));
      end
      $display("test rate follow done");
      for (int i = 0; i < 5; i++) begin
         v[i] = 7'($urandom_range(8, 1));
         wr(ad(i), {1'b1, v[i]}, 2'b00);
         lenQ.push_back({1'b0, v[i]});
      end
      wr(12'h120, 8'h01, 2'b00);
      for (int i = 0; i < 5; i++) begin
         rd(ad(i), {26'h0, 1'b1, v[i]});
      end
      $display("test override done");
      hsReq <= 1'b1;
      while (!hsActive) @(posedge core_clk);
      rd(12'h124, 34'h0C);
      hsReq <= 1'b0;
      while (lenQ.size() != 0) @(posedge core_clk);
      $display("test burst timing done");
      for (int i = 0; i < 5; i++) begin
         wr(ad(i), 8'h00, 2'b00);
         rd(ad(i), 34'(rv[i]));
      end
      wr(12'h1F0, 8'hFF, 2'b11);
      rd(12'h1F0, {2'b11, 32'h00000000});
      $display("test release and unmapped done");
      stop_test();
   end
endmodule
